// *** acpr_conv_model.sv ***
// behavioural model of the sampling converter pins
`timescale 1ns/1ps
module acpr_conv_model #(
  parameter int CONV_NS = 420,
  parameter int WAKE_NS = 1000,
  parameter int EOC_NS  = 100
) (
  // strobes and address from the host
  input  wire logic       convert_start_n_i,
  input  wire logic       select_n_i,
  input  wire logic       read_n_i,
  input  wire logic [2:0] addr_i,
  // answers
  output logic            eoc_n_o,
  output logic [7:0]      data_o,
  output int              pd_count_o
);
  logic [7:0] result_reg = 8'h00;
  logic [2:0] chan_reg   = 3'h0;
  logic [4:0] seq_reg    = 5'h00;
  logic       awake_reg  = 1'b0;
  logic       cs_prev;
  time        ready_at   = 0;
  initial eoc_n_o = 1'b1;
  initial pd_count_o = 0;
  // released bus shows the inverse of the last result so a stale sample is caught
  assign data_o = (!select_n_i && !read_n_i) ? result_reg : ~result_reg;
  always @(negedge read_n_i) if (!select_n_i) chan_reg = addr_i;
  // only a real low-to-high step wakes it; the unknown-to-high step at start-up does not
  always @(convert_start_n_i) begin
    if (cs_prev === 1'b0 && convert_start_n_i === 1'b1 && !awake_reg) begin
      awake_reg = 1'b1;
      ready_at = $time + WAKE_NS;
    end
    cs_prev = convert_start_n_i;
  end
  // a start while asleep is ignored, a start during wake-up waits for it
  always @(negedge convert_start_n_i) if (awake_reg) begin
    if ($time < ready_at) #(ready_at - $time);
    #(CONV_NS);
    result_reg = {chan_reg, seq_reg};
    seq_reg = seq_reg + 5'h01;
    eoc_n_o = 1'b0;
    fork
      #(EOC_NS);
      @(posedge read_n_i);
    join_any
    disable fork;
    eoc_n_o = 1'b1;
    if (!convert_start_n_i) begin
      awake_reg = 1'b0;
      pd_count_o = pd_count_o + 1;
    end
  end
endmodule

// *** acpr_fifo.sv ***
// small result fifo with valid and ready on both sides
`timescale 1ns/1ps
module acpr_fifo #(
  parameter int unsigned WIDTH = 11,
  parameter int unsigned DEPTH = 4
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  // the wrap bit trick for full and empty needs a power-of-two depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("depth must be a power of two");
  end
  if (WIDTH < 1) begin : g_bad_width
    $error("width must be positive");
  end
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wr_reg;
  logic [AW:0]      rd_reg;
  wire              full  = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
  wire              empty = (wr_reg == rd_reg);
  wire              push  = in_valid_i && !full;
  wire              pop   = out_ready_i && !empty;
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem_reg[rd_reg[AW-1:0]];
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      if (push) wr_reg <= wr_reg + 1'b1;
      if (pop) rd_reg <= rd_reg + 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (push) mem_reg[wr_reg[AW-1:0]] <= in_data_i;
  end
endmodule

// *** acpr_host.sv ***
// host controller that drives the sampling converter through its pins
// Summary of operation
// - wait at least 30 ns after a read before the next conversion start
// - in power-down mode hold convert_start_n low until end-of-conversion rises
// - select may stay low; read alone accesses the result (here select is driven with the same strobe as read)
// - end-of-conversion could drive select and read directly
// - end-of-conversion falling edge is treated as result-ready event
// - channel bits stay independent of chip selection
// - on-chip reference: wait 25 us after wake before starting
`timescale 1ns/1ps
module acpr_host
  import acpr_pkg::*;
#(
  parameter int unsigned PWRUP_INT_CYCLES = PWRUP_INT_CYC,
  parameter int unsigned FDEPTH           = FIFO_DEPTH
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // user command side
  input  wire logic              start_i,
  input  wire logic [CH_W-1:0]   channel_i,
  input  wire logic              auto_powerdown_i,
  input  wire logic              internal_ref_i,
  output logic                   busy_o,
  // results, tagged with the channel converted
  output logic                   result_valid_o,
  input  wire logic              result_ready_i,
  output logic [DATA_W-1:0]      result_data_o,
  output logic [CH_W-1:0]        result_channel_o,
  // converter pins
  output logic                   convert_start_n_o,
  output logic                   select_n_o,
  output logic                   read_n_o,
  output logic                   channel_addr_bit2_o,
  output logic                   channel_addr_bit1_o,
  output logic                   channel_addr_bit0_o,
  input  wire logic              eoc_n_i,
  input  wire logic [DATA_W-1:0] data_i
);
  // refuse settings that the 16-bit cycle counter or the fifo cannot serve
  if (PWRUP_INT_CYCLES < 1 || PWRUP_INT_CYCLES > 32'h0000_ffff) begin : g_bad_pwrup
    $error("power-up count must fit the cycle counter");
  end
  if (FDEPTH < 2 || (FDEPTH & (FDEPTH - 1)) != 0) begin : g_bad_depth
    $error("fifo depth must be a power of two");
  end

  function automatic logic [15:0] cyc16(input int unsigned n);
    cyc16 = 16'(n);
  endfunction

  // pin synchronisers
  logic              eoc_s1_reg;
  logic              eoc_s2_reg;
  logic              eoc_old_reg;
  logic [DATA_W-1:0] dat_s1_reg;
  logic [DATA_W-1:0] dat_s2_reg;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      eoc_s1_reg  <= 1'b1;
      eoc_s2_reg  <= 1'b1;
      eoc_old_reg <= 1'b1;
      dat_s1_reg  <= '0;
      dat_s2_reg  <= '0;
    end else begin
      eoc_s1_reg  <= eoc_n_i;
      eoc_s2_reg  <= eoc_s1_reg;
      eoc_old_reg <= eoc_s2_reg;
      dat_s1_reg  <= data_i;
      dat_s2_reg  <= dat_s1_reg;
    end
  end
  wire eoc_fall = eoc_old_reg && !eoc_s2_reg;
  wire eoc_rise = !eoc_old_reg && eoc_s2_reg;

  acpr_state_t       state_reg;
  acpr_state_t       state_next;
  logic [15:0]       cnt_reg;
  logic [15:0]       cnt_next;
  logic              cs_reg;
  logic              cs_next;
  logic              rd_reg;
  logic              rd_next;
  logic              sleep_reg;
  logic              sleep_next;
  logic              mode_reg;
  logic              mode_next;
  logic [CH_W-1:0]   ch_reg;
  logic [CH_W-1:0]   ch_next;
  logic [CH_W-1:0]   conv_ch_reg;
  logic [CH_W-1:0]   conv_ch_next;
  logic [CH_W-1:0]   addr_reg;
  logic [CH_W-1:0]   addr_next;
  logic              push;
  logic              fifo_ready;
  wire               cnt_done = (cnt_reg == 16'h0000);
  wire [15:0]        cnt_dec  = cnt_reg - 16'h0001;
  wire [15:0]        wake_cyc = internal_ref_i ? cyc16(PWRUP_INT_CYCLES) : cyc16(1);

  always_comb begin
    state_next   = state_reg;
    cnt_next     = cnt_done ? cnt_reg : cnt_dec;
    cs_next      = cs_reg;
    rd_next      = rd_reg;
    sleep_next   = sleep_reg;
    mode_next    = mode_reg;
    ch_next      = ch_reg;
    conv_ch_next = conv_ch_reg;
    addr_next    = addr_reg;
    push         = 1'b0;
    case (state_reg)
      ACPR_IDLE: begin
        if (start_i && fifo_ready) begin
          mode_next = auto_powerdown_i;
          addr_next = channel_i;
          if (sleep_reg) begin
            cs_next    = 1'b1;
            state_next = ACPR_WAKE;
            cnt_next   = 16'h0001;
          end else begin
            cs_next    = 1'b0;
            state_next = ACPR_CONV;
            cnt_next   = cyc16(CONV_LOW_CYC);
          end
        end
      end
      ACPR_WAKE: begin
        // convert_start_n is low while asleep; raising it wakes the converter
        cs_next    = 1'b1;
        sleep_next = 1'b0;
        state_next = ACPR_PWRUP;
        cnt_next   = wake_cyc;
      end
      ACPR_PWRUP: begin
        if (cnt_done) begin
          cs_next    = 1'b0;
          state_next = ACPR_CONV;
          cnt_next   = cyc16(CONV_LOW_CYC);
        end
      end
      ACPR_CONV: begin
        // high-speed mode releases start early, well before the result is due
        if (cnt_done && !mode_reg) cs_next = 1'b1;
        conv_ch_next = ch_reg;
        if (eoc_fall) begin
          state_next = ACPR_WAIT;
          cnt_next   = cyc16(EOC_WAIT_CYC);
        end
      end
      ACPR_WAIT: begin
        // power-down mode keeps start low past the end-of-conversion rise
        if (!mode_reg) cs_next = 1'b1;
        if (eoc_rise || cnt_done) begin
          sleep_next = mode_reg;
          rd_next    = 1'b0;
          ch_next    = addr_reg;
          state_next = ACPR_READ;
          cnt_next   = cyc16(RD_LOW_CYC + 2);
        end
      end
      ACPR_READ: begin
        if (cnt_done) begin
          rd_next    = 1'b1;
          push       = 1'b1;
          state_next = ACPR_GAP;
          cnt_next   = cyc16(READ_GAP_CYC);
        end
      end
      ACPR_GAP: begin
        if (cnt_done) state_next = ACPR_IDLE;
      end
      default: begin
        state_next = ACPR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg   <= ACPR_IDLE;
      cnt_reg     <= '0;
      // start held low in reset: a stray conversion ends in power-down,
      // so the converter is asleep as assumed and the first start gives a rising edge
      cs_reg      <= 1'b0;
      rd_reg      <= 1'b1;
      sleep_reg   <= 1'b1;
      mode_reg    <= 1'b0;
      ch_reg      <= CH_RESET;
      conv_ch_reg <= CH_RESET;
      addr_reg    <= CH_RESET;
    end else begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      cs_reg      <= cs_next;
      rd_reg      <= rd_next;
      sleep_reg   <= sleep_next;
      mode_reg    <= mode_next;
      ch_reg      <= ch_next;
      conv_ch_reg <= conv_ch_next;
      addr_reg    <= addr_next;
    end
  end

  // limitation: a full fifo stalls new conversions rather than dropping results
  acpr_fifo #(
    .WIDTH (DATA_W + CH_W),
    .DEPTH (FDEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (push),
    .in_ready_o  (fifo_ready),
    .in_data_i   ({conv_ch_reg, dat_s2_reg}),
    .out_valid_o (result_valid_o),
    .out_ready_i (result_ready_i),
    .out_data_o  ({result_channel_o, result_data_o})
  );

  assign busy_o              = (state_reg != ACPR_IDLE);
  assign convert_start_n_o   = cs_reg;
  // own read strobe instead of looping end-of-conversion back, so data is sampled on our clock
  assign select_n_o          = rd_reg;
  assign read_n_o            = rd_reg;
  assign channel_addr_bit2_o = addr_reg[2];
  assign channel_addr_bit1_o = addr_reg[1];
  assign channel_addr_bit0_o = addr_reg[0];
endmodule

// *** acpr_host_monitor.sv ***
// pin-level assertions for the converter host controller
`timescale 1ns/1ps
module acpr_host_monitor
  import acpr_pkg::*;
(
  // clock and reset
  input wire logic              clk_i,
  input wire logic              rst_i,
  // user side
  input wire logic              busy_o,
  input wire logic              auto_powerdown_i,
  input wire logic              result_valid_o,
  input wire logic              result_ready_i,
  input wire logic [DATA_W-1:0] result_data_o,
  // converter pins
  input wire logic              convert_start_n_o,
  input wire logic              select_n_o,
  input wire logic              read_n_o,
  input wire logic              channel_addr_bit2_o,
  input wire logic              channel_addr_bit1_o,
  input wire logic              channel_addr_bit0_o,
  input wire logic              eoc_n_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [2:0] addr_w;
  assign addr_w = {channel_addr_bit2_o, channel_addr_bit1_o, channel_addr_bit0_o};
  sequence s_read_rest;
    !read_n_o [*4] ##1 read_n_o;
  endsequence
  sequence s_start_rest;
    !convert_start_n_o [*4] ##1 convert_start_n_o;
  endsequence
  a_strobes_tied: assert property (select_n_o == read_n_o) else $error("select and read differ");
  a_read_four: assert property ($fell(read_n_o) |=> s_read_rest) else $error("read strobe length");
  a_addr_read_hold: assert property (!read_n_o |-> $stable(addr_w)) else $error("address moved in read");
  a_read_gap_min: assert property ($rose(read_n_o) |=> !$fell(convert_start_n_o) [*2]) else $error("gap short");
  // start may not move while the converter reports completion
  a_start_steady_eoc: assert property (!eoc_n_i |-> $stable(convert_start_n_o)) else $error("start moved");
  a_hs_start_len: assert property ($fell(convert_start_n_o) && !auto_powerdown_i |=> s_start_rest)
    else $error("start pulse length");
  a_eoc_to_read: assert property ($fell(eoc_n_i) |-> ##[1:80] $fell(read_n_o)) else $error("no read");
  a_idle_no_read: assert property (!busy_o |-> read_n_o) else $error("read while idle");
  a_result_hold: assert property (result_valid_o && !result_ready_i |=> result_valid_o && $stable(result_data_o))
    else $error("result dropped");
endmodule
bind acpr_host acpr_host_monitor u_mon (
  .clk_i               (clk_i),
  .rst_i               (rst_i),
  .busy_o              (busy_o),
  .auto_powerdown_i    (auto_powerdown_i),
  .result_valid_o      (result_valid_o),
  .result_ready_i      (result_ready_i),
  .result_data_o       (result_data_o),
  .convert_start_n_o   (convert_start_n_o),
  .select_n_o          (select_n_o),
  .read_n_o            (read_n_o),
  .channel_addr_bit2_o (channel_addr_bit2_o),
  .channel_addr_bit1_o (channel_addr_bit1_o),
  .channel_addr_bit0_o (channel_addr_bit0_o),
  .eoc_n_i             (eoc_n_i)
);

// *** acpr_pkg.sv ***
// constants shared by the converter host controller
package acpr_pkg;
  localparam int unsigned CLK_MHZ         = 40;
  localparam int unsigned READ_GAP_NS     = 30;
  localparam int unsigned EOC_MAX_NS      = 110;
  localparam int unsigned SAMPLE_MAX_NS   = 530;
  localparam int unsigned PWRUP_EXT_NS    = 1000;
  localparam int unsigned PWRUP_INT_NS    = 25000;
  localparam int unsigned CONV_LOW_NS     = 100;
  localparam int unsigned RD_LOW_NS       = 50;
  // least times round up
  localparam int unsigned READ_GAP_CYC    = (READ_GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CONV_LOW_CYC    = (CONV_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RD_LOW_CYC      = (RD_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SAMPLE_WAIT_CYC = (SAMPLE_MAX_NS * CLK_MHZ + 999) / 1000 + 2;
  localparam int unsigned PWRUP_EXT_CYC   = (PWRUP_EXT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PWRUP_INT_CYC   = (PWRUP_INT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned EOC_WAIT_CYC    = 64;
  localparam int unsigned DATA_W          = 8;
  localparam int unsigned CH_W            = 3;
  localparam logic [2:0]  CH_RESET        = 3'h0;
  localparam int unsigned FIFO_DEPTH      = 4;
  typedef enum logic [6:0] {
    ACPR_IDLE   = 7'h01,
    ACPR_WAKE   = 7'h02,
    ACPR_PWRUP  = 7'h04,
    ACPR_CONV   = 7'h08,
    ACPR_WAIT   = 7'h10,
    ACPR_READ   = 7'h20,
    ACPR_GAP    = 7'h40
  } acpr_state_t;
endpackage

// *** test_adc_convert_powerdown_readout.sv ***
// self-checking bench for the converter host controller
`timescale 1ns/1ps
module test_adc_convert_powerdown_readout
  import acpr_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        start_i = 1'b0, auto_powerdown_i = 1'b0, internal_ref_i = 1'b0, result_ready_i = 1'b0;
  logic [2:0]  channel_i = 3'h0, result_channel_o, prev_ch = 3'h0;
  logic        busy_o, result_valid_o, convert_start_n_o, select_n_o, read_n_o, eoc_n_i;
  logic        channel_addr_bit2_o, channel_addr_bit1_o, channel_addr_bit0_o;
  logic [7:0]  result_data_o, data_i;
  logic [4:0]  seq = 5'h00;
  logic [10:0] exp_q[$];
  int          pd_count, bad_count = 0, check_count = 0;
  always #12.5 clk_i = ~clk_i;
  // short wake count keeps the internal reference case brief
  acpr_host #(.PWRUP_INT_CYCLES(10)) dut (
    .clk_i               (clk_i),
    .rst_i               (rst_i),
    .start_i             (start_i),
    .channel_i           (channel_i),
    .auto_powerdown_i    (auto_powerdown_i),
    .internal_ref_i      (internal_ref_i),
    .busy_o              (busy_o),
    .result_valid_o      (result_valid_o),
    .result_ready_i      (result_ready_i),
    .result_data_o       (result_data_o),
    .result_channel_o    (result_channel_o),
    .convert_start_n_o   (convert_start_n_o),
    .select_n_o          (select_n_o),
    .read_n_o            (read_n_o),
    .channel_addr_bit2_o (channel_addr_bit2_o),
    .channel_addr_bit1_o (channel_addr_bit1_o),
    .channel_addr_bit0_o (channel_addr_bit0_o),
    .eoc_n_i             (eoc_n_i),
    .data_i              (data_i)
  );
  acpr_conv_model model (.convert_start_n_i(convert_start_n_o), .select_n_i(select_n_o), .read_n_i(read_n_o),
    .addr_i({channel_addr_bit2_o, channel_addr_bit1_o, channel_addr_bit0_o}), .eoc_n_o(eoc_n_i),
    .data_o(data_i), .pd_count_o(pd_count));
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [10:0] exp, input logic [10:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(inout int n);
    @(posedge clk_i);
    #1;
    n++;
    if (n > 3000) begin
      cmp("wait bound", 11'h0, 11'h1);
      wrap_up();
    end
  endtask
  task automatic kick(input logic [2:0] ch, input logic apd, input logic iref, input logic taken);
    int n;
    n = 0;
    @(posedge clk_i);
    start_i <= 1'b1;
    channel_i <= ch;
    auto_powerdown_i <= apd;
    internal_ref_i <= iref;
    @(posedge clk_i);
    start_i <= 1'b0;
    tick(n);
    tick(n);
    while (busy_o !== 1'b0) tick(n);
    if (taken) begin
      exp_q.push_back({prev_ch, prev_ch, seq});
      prev_ch = ch;
      seq++;
    end
  endtask
  task automatic pull;
    int n;
    logic [10:0] e;
    n = 0;
    e = exp_q.pop_front();
    #1;
    while (result_valid_o !== 1'b1) tick(n);
    cmp("result", e, {result_channel_o, result_data_o});
    @(posedge clk_i);
    result_ready_i <= 1'b1;
    @(posedge clk_i);
    result_ready_i <= 1'b0;
  endtask
  task automatic t_hop;
    int p0;
    p0 = pd_count;
    for (int i = 0; i < 8; i++) begin
      kick(3'(i * 5 + 3), 1'b0, 1'b0, 1'b1);
      pull();
    end
    cmp("power-downs", 11'(p0), 11'(pd_count));
    $display("channel hopping done");
  endtask
  task automatic t_fill;
    int p0;
    p0 = pd_count;
    for (int i = 0; i < 4; i++) kick(3'(i), 1'b1, 1'b0, 1'b1);
    cmp("power-downs", 11'(p0 + 4), 11'(pd_count));
    kick(3'h7, 1'b1, 1'b0, 1'b0);
    cmp("refused start", 11'(p0 + 4), 11'(pd_count));
    repeat (4) pull();
    #1 cmp("drained", 11'h0, 11'(result_valid_o));
    $display("fill and drain done");
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    #1 cmp("idle pins", 11'h2, {8'h00, convert_start_n_o, read_n_o, busy_o});
    t_hop();
    t_fill();
    kick(3'h4, 1'b1, 1'b1, 1'b1);
    pull();
    $display("internal reference done");
    wrap_up();
  end
endmodule
